// ===== rtl/cod_cfg.svh
`ifndef COD_CFG_SVH
`define COD_CFG_SVH

// ----------------------------------------------------------------
// Divider select field
// ----------------------------------------------------------------
`define COD_SEL_MSB 1
`define COD_SEL_LSB 0
`define COD_SEL_RESET 2'h0

// ----------------------------------------------------------------
// Divider terminal counts (half period minus one, in clocks)
// ----------------------------------------------------------------
`define COD_TERM_DIV4 2'h1
`define COD_TERM_DIV2 2'h0

`endif

// ===== rtl/cod_pkg.sv
package cod_pkg;

  // ----------------------------------------------------------------
  // Divider select codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    COD_DIV4 = 2'h0,
    COD_DIV2 = 2'h1,
    COD_DIV1 = 2'h2,
    COD_OFF  = 2'h3
  } cod_sel_t;

  // ----------------------------------------------------------------
  // Switch sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    COD_ST_RUN      = 2'b00,
    COD_ST_GATE_OFF = 2'b01,
    COD_ST_STOPPED  = 2'b10
  } cod_state_t;

  // ----------------------------------------------------------------
  // Pin bundle for the clock output
  // ----------------------------------------------------------------
  typedef struct packed {
    logic oe;
    logic div_level;
  } cod_pin_t;

endpackage

// ===== rtl/cod_div.sv
`include "cod_cfg.svh"

module cod_div #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Control
  input wire logic run,
  input wire logic clr,
  input wire logic [W-1:0] term,
  // Result
  output logic tick
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  wire logic at_term;

  // ----------------------------------------------------------------
  // Half-period counter
  // ----------------------------------------------------------------
  assign at_term = (cnt_q == term);
  assign tick = run & at_term;

  always_comb begin
    cnt_d = cnt_q;
    if (clr || !run || at_term) begin
      cnt_d = '0;
    end else begin
      cnt_d = cnt_q + {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

// ===== rtl/cod_top.sv
// Functional notes
// - Clock output runs at system clock, half, or quarter rate, chosen by software.
// - Divide select is a two-bit field at bits 1 and 0.
// - After reset the select field gives a quarter-rate clock output.
// - Select code 3 stops the clock output toggling.
// - Clock output pin stays actively driven while reset is asserted.
`include "cod_cfg.svh"

module cod_top
  import cod_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Control from device logic
  input wire logic [1:0] out_clock_divide_sel,
  // Clock output pin
  output logic ext_clock_out,
  output logic ext_clock_oe,
  // Status
  output logic [1:0] active_sel
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cod_state_t state_q;
  cod_state_t state_d;
  cod_sel_t act_q;
  cod_sel_t act_d;
  cod_pin_t pin_q;
  cod_pin_t pin_d;
  logic out_q;
  logic out_d;
  logic full_q;
  logic full_d;
  logic gate_en_q;
  logic gate_en_d;
  logic gate_q;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire cod_sel_t req;
  wire logic req_new;
  wire logic div_run;
  wire logic [1:0] div_term;
  wire logic tick;
  wire logic fall_pt;
  wire logic apply;

  assign req = cod_sel_t'(out_clock_divide_sel[`COD_SEL_MSB:`COD_SEL_LSB]);
  assign req_new = (req != act_q);
  assign div_run = (act_q == COD_DIV4) || (act_q == COD_DIV2);
  assign div_term = (act_q == COD_DIV4) ? `COD_TERM_DIV4 : `COD_TERM_DIV2;
  // Change only on a falling edge so no runt pulse reaches the board
  assign fall_pt = out_q & tick;
  assign apply = req_new && (state_q == COD_ST_RUN) && div_run && fall_pt;

  // ----------------------------------------------------------------
  // Transition decode
  // ----------------------------------------------------------------
  wire logic in_run;
  wire logic in_stopped;
  wire logic want_full;
  wire logic want_off;
  wire logic leave_full;
  wire logic wake;

  assign in_run = (state_q == COD_ST_RUN);
  assign in_stopped = (state_q == COD_ST_STOPPED);
  assign want_full = (req == COD_DIV1);
  assign want_off = (req == COD_OFF);
  // Full rate is left through the gate-off state, so the gate drops while the clock is low
  assign leave_full = in_run && full_q && req_new;
  assign wake = in_stopped && req_new;

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  // Held clear outside the divided modes, so a restart opens with a whole low phase
  cod_div #(
    .W(2)
  ) u_div (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .run(div_run),
    .clr(apply),
    .term(div_term),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // Switch sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    act_d = act_q;
    out_d = out_q ^ tick;
    full_d = full_q;
    gate_en_d = gate_en_q;
    case (state_q)
      COD_ST_RUN: begin
        if (full_q) begin
          out_d = 1'b0;
          if (leave_full) begin
            gate_en_d = 1'b0;
            state_d = COD_ST_GATE_OFF;
          end
        end else if (apply) begin
          out_d = 1'b0;
          act_d = req;
          if (want_full) begin
            full_d = 1'b1;
            gate_en_d = 1'b1;
          end else if (want_off) begin
            state_d = COD_ST_STOPPED;
          end
        end
      end
      COD_ST_GATE_OFF: begin
        // Gate drops on the falling edge inside this state, after one last high phase; divided level is held low
        out_d = 1'b0;
        full_d = 1'b0;
        act_d = req;
        state_d = want_off ? COD_ST_STOPPED : COD_ST_RUN;
        if (want_full) begin
          full_d = 1'b1;
          gate_en_d = 1'b1;
          state_d = COD_ST_RUN;
        end
      end
      COD_ST_STOPPED: begin
        out_d = 1'b0;
        if (wake) begin
          act_d = req;
          state_d = COD_ST_RUN;
          if (want_full) begin
            full_d = 1'b1;
            gate_en_d = 1'b1;
          end
        end
      end
      default: begin
        state_d = COD_ST_RUN;
        out_d = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= COD_ST_RUN;
      act_q <= cod_sel_t'(`COD_SEL_RESET);
    end else begin
      state_q <= state_d;
      act_q <= act_d;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= 1'b0;
    end else begin
      out_q <= out_d;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      full_q <= 1'b0;
      gate_en_q <= 1'b0;
    end else begin
      full_q <= full_d;
      gate_en_q <= gate_en_d;
    end
  end

  // ----------------------------------------------------------------
  // Full-rate gate
  // ----------------------------------------------------------------
  // Enable moves while the clock is low, so the gated clock has no glitch
  always_ff @(negedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_q <= 1'b0;
    end else begin
      gate_q <= gate_en_q;
    end
  end

  // ----------------------------------------------------------------
  // Pin registers
  // ----------------------------------------------------------------
  // Enable never drops, reset included, so the board never sees a floating clock
  assign pin_d = '{oe: 1'b1, div_level: out_d};

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_q <= '{oe: 1'b1, div_level: 1'b0};
    end else begin
      pin_q <= pin_d;
    end
  end

  // ----------------------------------------------------------------
  // Output drive
  // ----------------------------------------------------------------
  wire logic gated_clk;
  wire logic pin_level;

  // Undivided rate cannot come from a flop on this clock; it is a gated copy
  // The board sees it only after the gate flop has risen with the clock low
  assign gated_clk = ref_clk & gate_q;
  assign pin_level = full_q ? gated_clk : pin_q.div_level;
  assign ext_clock_out = pin_level;
  assign ext_clock_oe = pin_q.oe;
  assign active_sel = act_q;

endmodule

// ===== tb/cod_top_asserts.sv
module cod_top_asserts
  import cod_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Observed ports
  input wire logic [1:0] out_clock_divide_sel,
  input wire logic ext_clock_out,
  input wire logic ext_clock_oe,
  input wire logic [1:0] active_sel
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Change may take up to four cycles, so hold the request longer
  sequence req_held;
    (out_clock_divide_sel != active_sel) ##1 $stable(out_clock_divide_sel) [*5];
  endsequence
  rst_driven_a: assert property (disable iff (1'b0) !rst_n |-> ext_clock_oe && !ext_clock_out)
    else $error("clock pin not driven low in reset");
  rst_quarter_a: assert property ($rose(rst_n) |-> active_sel == COD_DIV4)
    else $error("reset divisor not quarter");
  sel_applied_a: assert property (req_held |-> active_sel == out_clock_divide_sel)
    else $error("select not applied");
  off_low_a: assert property (active_sel == COD_OFF |-> !ext_clock_out)
    else $error("clock toggles while off");
  div4_high_a: assert property ($rose(ext_clock_out) && active_sel == COD_DIV4 |-> ##1 ext_clock_out ##1 !ext_clock_out)
    else $error("quarter high phase wrong");
  div4_low_a: assert property ($fell(ext_clock_out) && active_sel == COD_DIV4 |-> ##1 !ext_clock_out ##1 ext_clock_out)
    else $error("quarter low phase wrong");
  div2_shape_a: assert property ($rose(ext_clock_out) && active_sel == COD_DIV2 |=> !ext_clock_out)
    else $error("half rate phase wrong");
  switch_low_a: assert property ($changed(active_sel) |-> !ext_clock_out)
    else $error("divisor switched with output high");
endmodule

bind cod_top cod_top_asserts u_chk (.ref_clk, .rst_n, .out_clock_divide_sel, .ext_clock_out,
  .ext_clock_oe, .active_sel);

// ===== tb/cod_board_model.sv
module cod_board_model (
  // Clock pin from the device
  input wire logic ext_clock_out,
  input wire logic ext_clock_oe,
  // Counter control and result
  input wire logic clr,
  output int rises
);
  timeunit 1ns;
  timeprecision 1ns;
  // Edges only count while the pin is driven, as a board load would see
  always @(posedge ext_clock_out or posedge clr) begin
    if (clr) rises <= 0;
    else if (ext_clock_oe) rises <= rises + 1;
  end
endmodule

// ===== tb/cod_top_test.sv
module cod_top_test
  import cod_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  // Starts high so the drop at 2 ns is an edge that the asynchronous reset sees
  logic rst_n = 1'b1;
  logic [1:0] sel = 2'h0;
  logic out, oe, clr;
  logic [1:0] act;
  int rises, got;
  int fail_count = 0;
  int n_compared = 0;
  logic [1:0] row_sel [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h1};
  int row_rises [5] = '{10, 20, 40, 0, 20};
  always #10 ref_clk = ~ref_clk;
  cod_top DUT (.ref_clk, .rst_n, .out_clock_divide_sel(sel), .ext_clock_out(out),
    .ext_clock_oe(oe), .active_sel(act));
  cod_board_model u_board (.ext_clock_out(out), .ext_clock_oe(oe), .clr(clr), .rises(rises));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  // Window of 40 cycles holds a whole number of periods for every divisor
  task automatic measure(input logic [1:0] s, output int n);
    sel = s;
    tick(12);
    clr = 1'b1;
    tick(1);
    clr = 1'b0;
    tick(40);
    n = rises;
  endtask
  task automatic conclude;
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    clr = 1'b1;
    #2;
    rst_n = 1'b0;
    tick(8);
    rst_n = 1'b1;
    check(act, COD_DIV4);
    for (int i = 0; i < 5; i++) begin
      measure(row_sel[i], got);
      check(got, row_rises[i]);
      check(act, row_sel[i]);
      $display("rate test %0d done", i);
    end
    sel = 2'h2;
    tick(1);
    sel = 2'h3;
    tick(1);
    measure(2'h0, got);
    check(got, 10);
    $display("back to back test done");
    sel = 2'h2;
    tick(10);
    rst_n = 1'b0;
    tick(1);
    check(oe, 1'b1);
    check(out, 1'b0);
    check(act, COD_DIV4);
    sel = 2'h0;
    rst_n = 1'b1;
    measure(2'h0, got);
    check(got, 10);
    $display("reset test done");
    conclude();
  end
  initial begin
    #20000;
    fail_count++;
    conclude();
  end
endmodule
